// file: design/wdtc_cfg.svh
`ifndef WDTC_CFG_SVH
`define WDTC_CFG_SVH

// Control register field positions
`define WDTC_SEL_MSB        2
`define WDTC_SEL_LSB        0
`define WDTC_EN_BIT         3
`define WDTC_TOE_BIT        4

// Reset values
`define WDTC_SEL_RST        3'h0
`define WDTC_CTL_RST        8'h00
`define WDTC_CNT_RST        22'h00_0000
`define WDTC_TOE_CNT_RST    3'h0

// Turn-off enable stays open for four system clock cycles
`define WDTC_TOE_CYCLES     3'h4
`define WDTC_TOE_DEC        3'h1

// Base timeout in oscillator cycles (select code zero)
`define WDTC_BASE_COUNT     22'h00_4000
`define WDTC_CNT_ONE        22'h00_0001

`endif

// file: design/wdtc_pkg.sv
package wdtc_pkg;

  // Turn-off window state, Gray coded
  typedef enum logic [1:0]
  {
    WDTC_OFF_SHUT = 2'b00,
    WDTC_OFF_OPEN = 2'b01
  } wdtc_off_t;

endpackage : wdtc_pkg

// file: design/wdtc_osc_sync.sv
`timescale 1ns/10ps
`default_nettype none

module wdtc_osc_sync
(
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_osc,
  output var  logic o_tick
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic lvl_d;
  logic tick_d;
  logic tick_q;

  // Level only moves once the second and third stages agree
  always_comb
  begin
    lvl_d  = (s2_q == s3_q) ? s3_q : lvl_q;
    tick_d = lvl_d & ~lvl_q;
  end

  // First stage feeds only the second one
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      lvl_q  <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      s1_q   <= i_osc;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;

endmodule : wdtc_osc_sync

`default_nettype wire

// file: design/wdtc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdtc_cfg.svh"

module wdtc_top
  import wdtc_pkg::*;
#(
  parameter logic [21:0] BASE_COUNT = `WDTC_BASE_COUNT
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_chip_rst,
  input  wire logic       i_wdt_osc,
  input  wire logic       i_restart,
  input  wire logic       i_ctl_we,
  input  wire logic [7:0] i_ctl_wdata,
  input  wire logic       i_cause_we,
  input  wire logic       i_cause_wdata,
  output var  logic [7:0] o_ctl_rdata,
  output var  logic       o_cause_flag,
  output var  logic       o_sys_rst
);

  // Timeout length for a select code
  function automatic logic [21:0] timeout_limit(input logic [2:0] sel);
    timeout_limit = BASE_COUNT << sel;
  endfunction : timeout_limit

  logic        tick;
  logic [2:0]  sel_q;
  logic [2:0]  sel_d;
  logic        en_q;
  logic        en_d;
  wdtc_off_t   off_q;
  wdtc_off_t   off_d;
  logic [2:0]  toe_cnt_q;
  logic [2:0]  toe_cnt_d;
  logic [21:0] cnt_q;
  logic [21:0] cnt_d;
  logic        rst_d;
  logic        rst_q;
  logic        flag_d;
  logic        flag_q;
  logic [7:0]  rdata_d;
  logic [7:0]  rdata_q;
  logic        expire;
  logic        toe_q;
  logic        wr_en;
  logic        wr_toe;

  assign toe_q  = (off_q == WDTC_OFF_OPEN);
  assign wr_en  = i_ctl_wdata[`WDTC_EN_BIT];
  assign wr_toe = i_ctl_wdata[`WDTC_TOE_BIT];

  // Oscillator sampled into the system clock domain
  wdtc_osc_sync u_osc_sync
  (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_osc  (i_wdt_osc),
    .o_tick (tick)
  );

  // Control register and turn-off window
  always_comb
  begin
    sel_d     = sel_q;
    en_d      = en_q;
    off_d     = off_q;
    toe_cnt_d = toe_cnt_q;
    if (off_q == WDTC_OFF_OPEN)
    begin
      toe_cnt_d = toe_cnt_q - `WDTC_TOE_DEC;
      if (toe_cnt_q == `WDTC_TOE_DEC)
      begin
        off_d = WDTC_OFF_SHUT;
      end
    end
    if (i_ctl_we)
    begin
      sel_d = i_ctl_wdata[`WDTC_SEL_MSB:`WDTC_SEL_LSB];
      if (wr_en)
      begin
        en_d = 1'b1;
      end
      else if (toe_q)
      begin
        en_d = 1'b0;
      end
      // A fresh arm only starts from a shut window; no reload
      if (wr_toe && (off_q == WDTC_OFF_SHUT))
      begin
        off_d     = WDTC_OFF_OPEN;
        toe_cnt_d = `WDTC_TOE_CYCLES;
      end
    end
    if (i_chip_rst)
    begin
      sel_d     = `WDTC_SEL_RST;
      en_d      = 1'b0;
      off_d     = WDTC_OFF_SHUT;
      toe_cnt_d = `WDTC_TOE_CNT_RST;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sel_q     <= `WDTC_SEL_RST;
      en_q      <= 1'b0;
      off_q     <= WDTC_OFF_SHUT;
      toe_cnt_q <= `WDTC_TOE_CNT_RST;
    end
    else
    begin
      sel_q     <= sel_d;
      en_q      <= en_d;
      off_q     <= off_d;
      toe_cnt_q <= toe_cnt_d;
    end
  end

  // Expiry uses >= so a smaller select takes effect at once
  assign expire = tick && en_q &&
                  (cnt_q >= timeout_limit(sel_q) - `WDTC_CNT_ONE);

  // Counter, reset pulse and cause flag
  always_comb
  begin
    cnt_d  = cnt_q;
    rst_d  = 1'b0;
    flag_d = flag_q;
    if (i_cause_we && !i_cause_wdata)
    begin
      flag_d = 1'b0;
    end
    if (!en_q || i_restart || i_chip_rst)
    begin
      cnt_d = `WDTC_CNT_RST;
    end
    else if (expire)
    begin
      cnt_d  = `WDTC_CNT_RST;
      rst_d  = 1'b1;
      flag_d = 1'b1;
    end
    else if (tick)
    begin
      cnt_d = cnt_q + `WDTC_CNT_ONE;
    end
    rdata_d = {3'h0, toe_q, en_d, sel_d};
    rdata_d[`WDTC_TOE_BIT] = (off_d == WDTC_OFF_OPEN);
  end

  // Flag survives chip resets; power-on or a cause write of zero clears it
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_q   <= `WDTC_CNT_RST;
      rst_q   <= 1'b0;
      flag_q  <= 1'b0;
      rdata_q <= `WDTC_CTL_RST;
    end
    else
    begin
      cnt_q   <= cnt_d;
      rst_q   <= rst_d;
      flag_q  <= flag_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_ctl_rdata  = rdata_q;
  assign o_cause_flag = flag_q;
  assign o_sys_rst    = rst_q;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  a_enable_set: assert property (
    i_ctl_we && wr_en && !i_chip_rst |=> en_q)
    else $error("enable not set by write");
  a_clear_refused: assert property (
    i_ctl_we && !wr_en && !toe_q && en_q && !i_chip_rst |=> en_q)
    else $error("enable cleared without turn-off bit");
  a_clear_in_window: assert property (
    i_ctl_we && wr_toe && wr_en && !toe_q && !i_chip_rst
    ##[1:4] (i_ctl_we && !wr_en && !i_chip_rst) |=> !en_q)
    else $error("disable within window failed");
  a_toe_self_clear: assert property (
    $rose(toe_q) && !i_chip_rst |-> toe_q[*4] ##1 !toe_q)
    else $error("turn-off bit not open exactly four cycles");
  a_sel_kept: assert property (
    i_ctl_we && !i_chip_rst |=> sel_q ==
      $past(i_ctl_wdata[`WDTC_SEL_MSB:`WDTC_SEL_LSB]))
    else $error("select field not stored");
  a_count_zero: assert property (
    (!en_q || i_restart) |=> cnt_q == `WDTC_CNT_RST)
    else $error("count not cleared");
  a_expiry_pulse: assert property (
    expire && !i_restart && !i_chip_rst |=> o_sys_rst ##1 !o_sys_rst)
    else $error("reset pulse not one cycle");
  a_pulse_cause: assert property (
    o_sys_rst |->
      $past(cnt_q) >= $past(timeout_limit(sel_q)) - `WDTC_CNT_ONE)
    else $error("reset pulse before selected count");
  a_flag_sticky: assert property (
    o_sys_rst |-> o_cause_flag)
    else $error("cause flag not set by watchdog reset");
  a_flag_hold: assert property (
    o_cause_flag && !(i_cause_we && !i_cause_wdata) |=> o_cause_flag)
    else $error("cause flag lost");

  c_disable_seq: cover property (toe_q && i_ctl_we && !wr_en ##1 !en_q);
  c_timeout: cover property (o_sys_rst);
  c_refused: cover property (i_ctl_we && !wr_en && !toe_q && en_q);

endmodule : wdtc_top

`default_nettype wire

// file: test/test_wdtc_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_wdtc_top;
  localparam logic [21:0] BASE = 22'h00_0010;
  logic       i_clk         = 1'b0;
  logic       i_rstn        = 1'b0;
  logic       i_chip_rst    = 1'b0;
  logic       i_wdt_osc     = 1'b0;
  logic       i_restart     = 1'b0;
  logic       i_ctl_we      = 1'b0;
  logic [7:0] i_ctl_wdata   = 8'h00;
  logic       i_cause_we    = 1'b0;
  logic       i_cause_wdata = 1'b0;
  logic [7:0] o_ctl_rdata;
  logic       o_cause_flag;
  logic       o_sys_rst;
  int         err_count     = 0;
  int         cmp_count     = 0;
  int         rst_cnt       = 0;
  // Write data beside the control view expected two edges later
  logic [7:0] rows [6][2]   = '{'{8'h08, 8'h08}, '{8'h00, 8'h08},
    '{8'h0d, 8'h0d}, '{8'h02, 8'h0a}, '{8'h1a, 8'h1a}, '{8'h00, 8'h10}};

  always #10 i_clk = ~i_clk;

  wdtc_top #(.BASE_COUNT(BASE)) dut
  (
    .i_clk         (i_clk),
    .i_rstn        (i_rstn),
    .i_chip_rst    (i_chip_rst),
    .i_wdt_osc     (i_wdt_osc),
    .i_restart     (i_restart),
    .i_ctl_we      (i_ctl_we),
    .i_ctl_wdata   (i_ctl_wdata),
    .i_cause_we    (i_cause_we),
    .i_cause_wdata (i_cause_wdata),
    .o_ctl_rdata   (o_ctl_rdata),
    .o_cause_flag  (o_cause_flag),
    .o_sys_rst     (o_sys_rst)
  );

  // Every high cycle counts, so a stretched pulse is seen
  always @(posedge i_clk) if (o_sys_rst === 1'b1) rst_cnt <= rst_cnt + 1;

  task end_sim;
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %0t: value %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task chkn(input int got, input int exp);
    cmp_count++;
    if (got != exp)
    begin
      err_count++;
      $display("Error %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : chkn

  task cyc(input int k);
    repeat (k) @(negedge i_clk);
  endtask : cyc

  // Strobe held one full cycle, then one idle cycle before the next
  task wr(input logic [7:0] d);
    i_ctl_we    = 1'b1;
    i_ctl_wdata = d;
    cyc(1);
    i_ctl_we    = 1'b0;
    cyc(1);
  endtask : wr

  // Oscillator edges well apart so the sampler sees each one
  task osc_run(input int lim, input int exp_n, input int exp_p);
    int r0;
    int k;
    r0 = rst_cnt;
    k  = 0;
    while (rst_cnt == r0 && k < lim)
    begin
      i_wdt_osc = 1'b1;
      cyc(4);
      i_wdt_osc = 1'b0;
      cyc(4);
      k++;
    end
    chkn(k, exp_n);
    chkn(rst_cnt - r0, exp_p);
  endtask : osc_run

  initial
  begin
    cyc(2);
    i_rstn = 1'b1;
    chk8(o_ctl_rdata, 8'h00);
    chk8({7'h00, o_cause_flag, o_sys_rst}, 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i][0]);
      chk8(o_ctl_rdata, rows[i][1]);
    end
    // Late disable after the turn-off window has lapsed
    cyc(3);
    wr(8'h18);
    chk8(o_ctl_rdata, 8'h18);
    cyc(2);
    chk8(o_ctl_rdata, 8'h18);
    cyc(1);
    chk8(o_ctl_rdata, 8'h08);
    wr(8'h00);
    chk8(o_ctl_rdata, 8'h08);
    // Restart, then arm twice and disable on the last open cycle of the first window
    i_restart = 1'b1;
    cyc(1);
    i_restart = 1'b0;
    wr(8'h18);
    wr(8'h18);
    wr(8'h00);
    chk8(o_ctl_rdata, 8'h00);
    for (int s = 0; s < 8; s++)
    begin
      wr({5'b00001, s[2:0]});
      osc_run(5000, int'(BASE) << s, 1);
      chk8({7'h00, o_cause_flag}, 8'h01);
      i_cause_we    = 1'b1;
      i_cause_wdata = s[0];
      cyc(1);
      i_cause_we    = 1'b0;
      cyc(1);
      chk8({7'h00, o_cause_flag}, {7'h00, s[0]});
    end
    wr(8'h08);
    osc_run(12, 12, 0);
    i_restart = 1'b1;
    cyc(1);
    i_restart = 1'b0;
    osc_run(100, int'(BASE), 1);
    i_chip_rst = 1'b1;
    cyc(1);
    i_chip_rst = 1'b0;
    chk8({o_ctl_rdata[6:0], o_cause_flag}, 8'h01);
    // Power-on reset clears the cause flag as well
    i_rstn = 1'b0;
    cyc(1);
    i_rstn = 1'b1;
    cyc(1);
    chk8({o_ctl_rdata[6:0], o_cause_flag}, 8'h00);
    end_sim();
  end
endmodule : test_wdtc_top
`default_nettype wire
